// ==== rtl/swag_pkg.sv ====
// Purpose: constants and types of the sine wave angle generator
// Assumes: byte-wide register port, one 200 MHz clock
// Notes: offsets are byte addresses on the register port
package swag_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam logic [15:0] OFS_ACTL = 16'h1FC0;
  localparam logic [15:0] OFS_CCTL = 16'h1FC1;
  localparam logic [15:0] OFS_PER_LO = 16'h1FC2;
  localparam logic [15:0] OFS_PER_HI = 16'h1FC3;
  localparam logic [15:0] OFS_IDX_LO = 16'h1FC4;
  localparam logic [15:0] OFS_IDX_HI = 16'h1FC5;
  localparam logic [15:0] OFS_TDATA = 16'h1FC6;
  localparam logic [15:0] OFS_AMP = 16'h1FC7;
  localparam logic [15:0] OFS_CAP_LO = 16'h1FC8;
  localparam logic [15:0] OFS_CAP_HI = 16'h1FC9;
  localparam int CC_START = 3;
  localparam int CC_BUSY = 2;
  localparam int CC_SYNC = 1;
  localparam int CC_ISEL = 0;
  localparam logic [7:0] ACTL_RST = 8'h00;
  localparam logic [8:0] ANG_LAST = 9'h17F;
  localparam logic [8:0] ANG_THIRD = 9'h080;
  localparam logic [8:0] ANG_HALF = 9'h0C0;
  localparam logic [8:0] ANG_STEPS = 9'h180;
  localparam int DIV_BASE = 3;
  localparam int DIV_W = 6;
  // phase-order calculation: read and compute per phase, then load
  localparam int CALC_BUSY_CYC = 7;
  typedef struct packed {
    logic dir;
    logic order;
    logic [1:0] clk_sel;
    logic three_ph;
    logic xfer_en;
    logic calc_en;
    logic tmr_en;
  } swag_actl_s;
  typedef struct packed {
    logic [11:0] u;
    logic [11:0] v;
    logic [11:0] w;
  } swag_cmp_s;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CALC, ST_LOAD} swag_state_e;
endpackage : swag_pkg

// ==== rtl/swag_top.sv ====
// Purpose: electrical angle timer, sine table and waveform arithmetic
// Assumes: i_pos_detect and i_pwm_period come from the motor control unit
// Notes: calc_control reads back only its flag and control bits
`timescale 1ns/1ps
`default_nettype none
// Contract
// - three-phase value changes sign at 180 degrees
// - writing one to soft start begins calculation; zero does nothing
// - busy flag reads one while calculating, zero when stopped
// - sync bit starts a calculation on every angle step
// - irq select: zero timer end, one calculation end
// - direction bit: zero counts up, one counts down
// - phase order: V,W = U plus or minus 120 and 240 degrees
// - clock select divides fc by 8, 16, 32 or 64
// - modulation select: zero two-phase, one three-phase
// - calc runs only when enabled; compare load only when transfer enabled
// - angle timer counts only while enabled
// - period equals (m + n/16) times 384 timer clocks
// - position detection copies angle counter into capture register
// - result is table sample times amplitude over 256, limited by PWM period
module swag_top
  import swag_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // motor control unit
  input wire logic i_pos_detect,
  input wire logic [11:0] i_pwm_period,
  output swag_cmp_s o_cmp,
  output logic o_cmp_load,
  output logic o_angle_irq
);
  swag_actl_s actl_r, actl_nxt;
  logic sync_r, sync_nxt, isel_r, isel_nxt;
  logic [11:0] per_m_r, per_m_nxt;
  logic [3:0] per_n_r, per_n_nxt;
  logic [8:0] idx_r, idx_nxt;
  logic [7:0] amp_r, amp_nxt;
  logic [8:0] cap_r, cap_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] table_mem [0:383];
  logic [7:0] ram_q;
  logic [8:0] ang_r, ang_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [12:0] stp_r, stp_nxt;
  logic [4:0] acc_r, acc_nxt;
  logic tick, step, wrap;
  logic pd_s1, pd_s2, pd_s3;
  swag_state_e st_r, st_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [8:0] cang_r, cang_nxt;
  swag_cmp_s cmp_r, cmp_nxt;
  logic load_r, load_nxt, irq_r, irq_nxt, done;
  logic soft_go, busy;
  logic [8:0] rd_ang;
  logic [15:0] prod;
  logic [11:0] mag, half, val;

  function automatic logic [8:0] ang_mod(input logic [8:0] a, input logic [8:0] d,
                                         input logic sub);
    logic [9:0] t;
    t = 10'h000;
    if (sub) begin
      t = {1'b0, a} + {1'b0, ANG_STEPS} - {1'b0, d};
    end else begin
      t = {1'b0, a} + {1'b0, d};
    end
    if (t >= {1'b0, ANG_STEPS}) begin
      t = t - {1'b0, ANG_STEPS};
    end
    return t[8:0];
  endfunction : ang_mod

  function automatic logic [11:0] clip(input logic [11:0] a, input logic [11:0] lim);
    return (a > lim) ? lim : a;
  endfunction : clip

  // register port
  assign soft_go = i_wr && (i_addr == OFS_CCTL) && i_wdata[CC_START];
  assign busy = (st_r != ST_IDLE);
  always_comb begin
    actl_nxt = actl_r;
    sync_nxt = sync_r;
    isel_nxt = isel_r;
    per_m_nxt = per_m_r;
    per_n_nxt = per_n_r;
    idx_nxt = idx_r;
    amp_nxt = amp_r;
    rdata_nxt = 8'h00;
    if (i_wr) begin
      unique case (i_addr)
        OFS_ACTL: actl_nxt = swag_actl_s'(i_wdata);
        OFS_CCTL: begin
          sync_nxt = i_wdata[CC_SYNC];
          isel_nxt = i_wdata[CC_ISEL];
        end
        OFS_PER_LO: per_m_nxt[7:0] = i_wdata;
        OFS_PER_HI: begin
          per_m_nxt[11:8] = i_wdata[3:0];
          per_n_nxt = i_wdata[7:4];
        end
        OFS_IDX_LO: idx_nxt[7:0] = i_wdata;
        OFS_IDX_HI: idx_nxt[8] = i_wdata[0];
        OFS_AMP: amp_nxt = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        OFS_ACTL: rdata_nxt = actl_r;
        OFS_CCTL: rdata_nxt = {4'h0, 1'b0, busy, sync_r, isel_r};
        OFS_PER_LO: rdata_nxt = per_m_r[7:0];
        OFS_PER_HI: rdata_nxt = {per_n_r, per_m_r[11:8]};
        OFS_IDX_LO: rdata_nxt = idx_r[7:0];
        OFS_IDX_HI: rdata_nxt = {7'h00, idx_r[8]};
        OFS_AMP: rdata_nxt = amp_r;
        OFS_CAP_LO: rdata_nxt = cap_r[7:0];
        OFS_CAP_HI: rdata_nxt = {7'h00, cap_r[8]};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      actl_r <= swag_actl_s'(ACTL_RST);
      sync_r <= 1'b0;
      isel_r <= 1'b0;
      per_m_r <= 12'h000;
      per_n_r <= 4'h0;
      idx_r <= 9'h000;
      amp_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      actl_r <= actl_nxt;
      sync_r <= sync_nxt;
      isel_r <= isel_nxt;
      per_m_r <= per_m_nxt;
      per_n_r <= per_n_nxt;
      idx_r <= idx_nxt;
      amp_r <= amp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign o_rdata = rdata_r;

  // sine table, written at the index, read by the arithmetic circuit
  always_ff @(posedge i_ref_clk) begin
    if (i_wr && (i_addr == OFS_TDATA) && (idx_r <= ANG_LAST)) begin
      table_mem[idx_r] <= i_wdata;
    end
    ram_q <= table_mem[rd_ang];
  end

  // angle timer: prescaler, fractional step length, angle counter
  assign tick = actl_r.tmr_en && (div_r[DIV_BASE-1 + actl_r.clk_sel -: 1] == 1'b1)
                && (div_r[DIV_BASE-2 + actl_r.clk_sel -: 1] == 1'b0)
                && ((div_r & ((6'h01 << (DIV_BASE - 2 + actl_r.clk_sel)) - 6'h01)) == 6'h00)
                && (div_r[DIV_BASE-1 + actl_r.clk_sel] ^ 1'b0);
  assign step = tick && (stp_r + 13'h0001 >= {1'b0, per_m_r} + {12'h000, acc_r[4]});
  assign wrap = step && (actl_r.dir ? (ang_r == 9'h000) : (ang_r == ANG_LAST));
  always_comb begin
    div_nxt = actl_r.tmr_en ? div_r + 6'h01 : 6'h00;
    stp_nxt = stp_r;
    acc_nxt = acc_r;
    ang_nxt = ang_r;
    if (tick) begin
      stp_nxt = stp_r + 13'h0001;
    end
    if (step) begin
      stp_nxt = 13'h0000;
      acc_nxt = {1'b0, acc_r[3:0]} + {1'b0, per_n_r};
      if (actl_r.dir) begin
        ang_nxt = (ang_r == 9'h000) ? ANG_LAST : ang_r - 9'h001;
      end else begin
        ang_nxt = (ang_r == ANG_LAST) ? 9'h000 : ang_r + 9'h001;
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 6'h00;
      stp_r <= 13'h0000;
      acc_r <= 5'h00;
      ang_r <= 9'h000;
    end else begin
      div_r <= div_nxt;
      stp_r <= stp_nxt;
      acc_r <= acc_nxt;
      ang_r <= ang_nxt;
    end
  end

  // position capture
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
      pd_s3 <= 1'b0;
      cap_r <= 9'h000;
    end else begin
      pd_s1 <= i_pos_detect;
      pd_s2 <= pd_s1;
      pd_s3 <= pd_s2;
      cap_r <= cap_nxt;
    end
  end
  assign cap_nxt = (pd_s2 && !pd_s3) ? ang_r : cap_r;

  // waveform arithmetic
  assign rd_ang = (ph_r == 2'd0) ? cang_r :
                  ang_mod(cang_r, (ph_r == 2'd1) ? ANG_THIRD : {ANG_THIRD[7:0], 1'b0},
                          actl_r.order);
  assign prod = ram_q * amp_r;
  assign half = {1'b0, i_pwm_period[11:1]};
  assign mag = clip({4'h0, prod[15:8]}, actl_r.three_ph ? half : i_pwm_period);
  assign val = !actl_r.three_ph ? mag :
               (rd_ang >= ANG_HALF) ? half - mag : half + mag;
  assign done = (st_r == ST_LOAD);
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    cang_nxt = cang_r;
    cmp_nxt = cmp_r;
    load_nxt = 1'b0;
    irq_nxt = isel_r ? done : wrap;
    unique case (st_r)
      ST_IDLE: begin
        if (actl_r.calc_en && (soft_go || (sync_r && step))) begin
          st_nxt = ST_READ;
          ph_nxt = 2'd0;
          cang_nxt = step ? ang_nxt : ang_r;
        end
      end
      ST_READ: st_nxt = ST_CALC;
      ST_CALC: begin
        unique case (ph_r)
          2'd0: cmp_nxt.u = val;
          2'd1: cmp_nxt.v = val;
          default: cmp_nxt.w = val;
        endcase
        ph_nxt = ph_r + 2'd1;
        st_nxt = (ph_r == 2'd2) ? ST_LOAD : ST_READ;
      end
      ST_LOAD: begin
        load_nxt = actl_r.xfer_en;
        st_nxt = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      ph_r <= 2'd0;
      cang_r <= 9'h000;
      cmp_r <= '0;
      load_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      cang_r <= cang_nxt;
      cmp_r <= cmp_nxt;
      load_r <= load_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign o_cmp = cmp_r;
  assign o_cmp_load = load_r;
  assign o_angle_irq = irq_r;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_soft;
    soft_go && actl_r.calc_en && !busy;
  endsequence
  sequence s_run;
    busy [*7] ##1 !busy;
  endsequence
  property p_calc_len;
    s_soft |=> s_run;
  endproperty
  a_calc_len: assert property (p_calc_len) else $error("calc length wrong");
  property p_zero_start;
    i_wr && (i_addr == OFS_CCTL) && !i_wdata[CC_START] && !busy && !sync_r |=> !busy;
  endproperty
  a_zero_start: assert property (p_zero_start) else $error("zero start ran");
  property p_no_calc;
    !actl_r.calc_en && !busy |=> !busy;
  endproperty
  a_no_calc: assert property (p_no_calc) else $error("calc while disabled");
  property p_xfer;
    o_cmp_load |-> $past(actl_r.xfer_en);
  endproperty
  a_xfer: assert property (p_xfer) else $error("load without transfer");
  property p_sync;
    actl_r.calc_en && sync_r && step && !busy |=> busy;
  endproperty
  a_sync: assert property (p_sync) else $error("no sync start");
  property p_stop;
    !actl_r.tmr_en |=> $stable(ang_r);
  endproperty
  a_stop: assert property (p_stop) else $error("angle moved");
  property p_up;
    step && !actl_r.dir && ang_r != ANG_LAST |=> ang_r == $past(ang_r) + 9'h001;
  endproperty
  a_up: assert property (p_up) else $error("bad up count");
  property p_wrap;
    step && !actl_r.dir && ang_r == ANG_LAST |=> ang_r == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad wrap");
  property p_cap;
    pd_s2 && !pd_s3 |=> cap_r == $past(ang_r);
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  property p_irq;
    !isel_r && wrap |=> o_angle_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("timer irq missing");
endmodule : swag_top
`default_nettype wire

// ==== verification/swag_tb.sv ====
// Purpose: self-checking bench of the sine wave angle generator
// Assumes: table entry i holds i/2, amplitude 8'hC0
// Notes: load pulses are counted by a monitor; one load marks one angle step
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module tb
  import swag_pkg::*;
;
  typedef struct {
    logic [7:0] actl;
    logic [7:0] cc;
    logic [11:0] per;
    logic [11:0] u;
    logic [11:0] v;
    logic [11:0] w;
    int ld;
    int irq;
  } swag_row_s;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic i_pos_detect = 1'b0;
  logic [11:0] i_pwm_period = 12'h0C8;
  swag_cmp_s o_cmp;
  logic o_cmp_load;
  logic o_angle_irq;
  int error_cnt = 0;
  int num_checks = 0;
  int load_cnt = 0;
  int irq_cnt = 0;
  time t_pp, t_p, t_l;
  swag_row_s rows [7];
  logic [7:0] d;
  int l0, q0, ang;
  swag_top swag_top_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pos_detect(i_pos_detect), .i_pwm_period(i_pwm_period), .o_cmp(o_cmp),
    .o_cmp_load(o_cmp_load), .o_angle_irq(o_angle_irq));
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (o_cmp_load === 1'b1) begin
      load_cnt++;
      t_pp = t_p;
      t_p = t_l;
      t_l = $time;
    end
    if (o_angle_irq === 1'b1) irq_cnt++;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
    v = o_rdata;
  endtask : rd
  task automatic wait_loads(input int n);
    int c0;
    int k;
    c0 = load_cnt;
    k = 0;
    while (load_cnt - c0 < n && k < 5000) begin
      @(posedge i_ref_clk);
      k++;
    end
    `CHK(k < 5000, 1'b1)
  endtask : wait_loads
  task automatic capture(input int exp);
    i_pos_detect <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    rd(OFS_CAP_LO, d);
    `CHK(d, exp[7:0])
    rd(OFS_CAP_HI, d);
    `CHK(d[0], exp[8])
    i_pos_detect <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
  endtask : capture
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    #150_000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    rows[0] = '{8'h06, 8'h08, 12'h0C8, 12'd0, 12'd48, 12'd96, 1, 0};
    rows[1] = '{8'h4E, 8'h09, 12'h0C8, 12'd100, 12'd4, 12'd148, 1, 1};
    rows[2] = '{8'h0A, 8'h08, 12'h0C8, 12'd100, 12'd148, 12'd4, 0, 0};
    rows[3] = '{8'h0C, 8'h09, 12'h0C8, 12'd100, 12'd148, 12'd4, 0, 0};
    rows[4] = '{8'h06, 8'h08, 12'h020, 12'd0, 12'd32, 12'd32, 1, 0};
    rows[5] = '{8'h0E, 8'h09, 12'h020, 12'd16, 12'd32, 12'd0, 1, 1};
    rows[6] = '{8'h06, 8'h01, 12'h020, 12'd16, 12'd32, 12'd0, 0, 0};
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(OFS_ACTL, d);
    `CHK(d, ACTL_RST)
    `CHK(o_cmp, 36'h0)
    `CHK(o_rdata, 8'h00)
    wr(16'h1FCA, 8'h5A);
    rd(16'h1FCA, d);
    `CHK(d, 8'h00)
    // table loaded with calculation disabled, plain writes only
    for (int i = 0; i < 384; i++) begin
      wr(OFS_IDX_LO, i[7:0]);
      wr(OFS_IDX_HI, {7'h00, i[8]});
      wr(OFS_TDATA, i[8:1]);
    end
    rd(OFS_TDATA, d);
    `CHK(d, 8'h00)
    wr(OFS_AMP, 8'hC0);
    $display("reset and table done");
    foreach (rows[r]) begin
      l0 = load_cnt;
      q0 = irq_cnt;
      wr(OFS_ACTL, rows[r].actl);
      i_pwm_period <= rows[r].per;
      wr(OFS_CCTL, rows[r].cc);
      rd(OFS_CCTL, d);
      `CHK(d[CC_BUSY], rows[r].actl[1] & rows[r].cc[3])
      repeat (12) @(posedge i_ref_clk);
      rd(OFS_CCTL, d);
      `CHK(d, {6'h00, rows[r].cc[1:0]})
      `CHK(o_cmp, {rows[r].u, rows[r].v, rows[r].w})
      `CHK(load_cnt - l0, rows[r].ld)
      `CHK(irq_cnt - q0, rows[r].irq)
    end
    $display("calculation rows done");
    wr(OFS_PER_LO, 8'h10);
    wr(OFS_PER_HI, 8'h00);
    wr(OFS_CCTL, 8'h02);
    l0 = load_cnt;
    wr(OFS_ACTL, 8'h07);
    wait_loads(3);
    `CHK(t_l - t_p, 640)
    wr(OFS_ACTL, 8'h06);
    repeat (300) @(posedge i_ref_clk);
    `CHK(load_cnt - l0, 3)
    wr(OFS_ACTL, 8'h16);
    wr(OFS_ACTL, 8'h17);
    wait_loads(3);
    `CHK(t_l - t_p, 1280)
    wr(OFS_ACTL, 8'h16);
    wr(OFS_ACTL, 8'h26);
    wr(OFS_ACTL, 8'h27);
    wait_loads(3);
    `CHK(t_l - t_p, 2560)
    wr(OFS_ACTL, 8'h26);
    wr(OFS_ACTL, 8'h36);
    wr(OFS_ACTL, 8'h37);
    wait_loads(3);
    `CHK(t_l - t_p, 5120)
    wr(OFS_ACTL, 8'h36);
    wr(OFS_ACTL, 8'h06);
    wr(OFS_PER_HI, 8'h80);
    wr(OFS_ACTL, 8'h07);
    wait_loads(3);
    `CHK((t_l - t_pp), 1320)
    wr(OFS_ACTL, 8'h06);
    ang = load_cnt - l0;
    capture(ang % 384);
    $display("timer up done");
    q0 = irq_cnt;
    wr(OFS_ACTL, 8'h86);
    wr(OFS_ACTL, 8'h87);
    wait_loads(ang + 2);
    wr(OFS_ACTL, 8'h86);
    `CHK(irq_cnt - q0, 1)
    capture(382);
    $display("timer down done");
    q0 = irq_cnt;
    wr(OFS_ACTL, 8'h06);
    wr(OFS_ACTL, 8'h07);
    wait_loads(2);
    wr(OFS_ACTL, 8'h06);
    `CHK(irq_cnt - q0, 1)
    capture(0);
    $display("up wrap done");
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    `CHK(o_cmp, 36'h0)
    `CHK(o_angle_irq, 1'b0)
    i_rst_n <= 1'b1;
    rd(OFS_CAP_LO, d);
    `CHK(d, 8'h00)
    rd(OFS_ACTL, d);
    `CHK(d, ACTL_RST)
    $display("mid-run reset done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
